// file: rtl/sfd_pkg.sv
// Package with constants and types for the switch forwarding decision block
package sfd_pkg;
  localparam int unsigned SFD_NPORT      = 5;
  localparam int unsigned SFD_CPU_PORT   = 4;
  localparam int unsigned SFD_VID_W      = 12;
  localparam int unsigned SFD_FID_W      = 7;
  localparam int unsigned SFD_VLAN_DEPTH = 128;
  localparam int unsigned SFD_VIDX_W     = 7;
  localparam int unsigned SFD_DYN_DEPTH  = 16;
  localparam int unsigned SFD_DYN_IDX_W  = 4;
  localparam int unsigned SFD_STA_DEPTH  = 8;
  localparam int unsigned SFD_STA_IDX_W  = 3;
  localparam int unsigned SFD_STAMP_W    = 8;
  // VLAN entry layout
  localparam int unsigned SFD_VE_W       = 13;
  localparam int unsigned SFD_VE_FID_LSB = 0;
  localparam int unsigned SFD_VE_MEM_LSB = 7;
  localparam int unsigned SFD_VE_VALID   = 12;
  // Static entry fields
  localparam int unsigned SFD_SE_MAP_LSB = 48;
  // Dynamic entry field
  localparam int unsigned SFD_DE_PORT_LSB = 56;
  // IPv6 next header codes
  localparam logic [7:0] SFD_NH_HOPBYHOP = 8'h00;
  localparam logic [7:0] SFD_NH_ICMP4    = 8'h01;
  localparam logic [7:0] SFD_NH_ICMP6    = 8'h3A;
  localparam logic [7:0] SFD_NH_ROUTE    = 8'h2B;
  localparam logic [7:0] SFD_NH_FRAG     = 8'h2C;
  localparam logic [7:0] SFD_NH_ESP      = 8'h32;
  localparam logic [7:0] SFD_NH_AUTH     = 8'h33;
  localparam logic [7:0] SFD_NH_DEST     = 8'h3C;
  localparam logic [7:0] SFD_HOP_ONE     = 8'h01;
  localparam logic [11:0] SFD_NULL_VID   = 12'h000;
  // Reset values
  localparam logic [4:0] SFD_MAP_RST     = 5'h00;
  localparam logic [7:0] SFD_TAG_RST     = 8'h00;
  localparam logic [7:0] SFD_STAMP_RST   = 8'h00;

  typedef enum logic [1:0] {
    SFD_DEST_FLOOD,
    SFD_DEST_DYNAMIC,
    SFD_DEST_STATIC
  } sfd_dest_t;
endpackage : sfd_pkg

// file: rtl/sfd_lookup_if.sv
// Interface carrying lookup requests and results between decision and tables
`timescale 1ns/1ps
interface sfd_lookup_if;
  logic [47:0] da;
  logic [47:0] sa;
  logic [6:0]  filter_id;
  logic        sta_hit;
  logic        sta_use_fid;
  logic [6:0]  sta_fid;
  logic [4:0]  sta_map;
  logic        dyn_da_hit;
  logic [2:0]  dyn_da_port;
  modport decide (output da, sa, filter_id,
                  input sta_hit, sta_use_fid, sta_fid, sta_map, dyn_da_hit, dyn_da_port);
  modport table_side (input da, sa, filter_id,
                      output sta_hit, sta_use_fid, sta_fid, sta_map, dyn_da_hit, dyn_da_port);
endinterface : sfd_lookup_if

// file: rtl/sfd_mac_tables.sv
// Static and dynamic MAC address tables with source learning
`timescale 1ns/1ps
module sfd_mac_tables
  import sfd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Lookup channel
  sfd_lookup_if.table_side lk,
  // Learning request
  input  wire logic        learn_in,
  input  wire logic [2:0]  learn_port_in,
  // Static table programming
  input  wire logic        sta_we_in,
  input  wire logic [2:0]  sta_idx_in,
  input  wire logic [63:0] sta_entry_in
);
  import sfd_pkg::*;

  logic [63:0] sta_mem [SFD_STA_DEPTH];
  logic [63:0] dyn_mem [SFD_DYN_DEPTH];
  logic [SFD_DYN_DEPTH-1:0] dyn_valid;
  logic [7:0]  dyn_stamp [SFD_DYN_DEPTH];
  logic [SFD_DYN_IDX_W-1:0] next_free;
  logic [7:0]  stamp_now;
  logic [SFD_DYN_DEPTH-1:0] learn_hit;

  // Static entry layout: [47:0] addr, [52:48] map, [53] valid, [54] use fid, [61:55] fid
  function automatic logic dyn_match(input logic [63:0] e, input logic [47:0] a,
                                     input logic [6:0] f);
    dyn_match = (e[47:0] == a) && (e[55:49] == f);
  endfunction

  // Static lookup on destination address
  always_comb begin
    lk.sta_hit     = 1'b0;
    lk.sta_use_fid = 1'b0;
    lk.sta_fid     = 7'h00;
    lk.sta_map     = SFD_MAP_RST;
    for (int i = 0; i < SFD_STA_DEPTH; i++) begin
      if (sta_mem[i][53] && (sta_mem[i][47:0] == lk.da) && !lk.sta_hit) begin
        lk.sta_hit     = 1'b1;
        lk.sta_use_fid = sta_mem[i][54];
        lk.sta_fid     = sta_mem[i][61:55];
        lk.sta_map     = sta_mem[i][SFD_SE_MAP_LSB +: 5];
      end
    end
  end

  // Dynamic lookup on filter id plus destination; entry [55:49] fid, [58:56] port
  always_comb begin
    lk.dyn_da_hit  = 1'b0;
    lk.dyn_da_port = 3'h0;
    for (int i = 0; i < SFD_DYN_DEPTH; i++) begin
      if (dyn_valid[i] && dyn_match(dyn_mem[i], lk.da, lk.filter_id) && !lk.dyn_da_hit) begin
        lk.dyn_da_hit  = 1'b1;
        lk.dyn_da_port = dyn_mem[i][SFD_DE_PORT_LSB +: 3];
      end
    end
  end

  // Static table writes
  always_ff @(posedge clk_sys_in) begin
    if (sta_we_in) begin
      sta_mem[sta_idx_in] <= sta_entry_in;
    end
  end

  // Free running time stamp
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      stamp_now <= SFD_STAMP_RST;
    end else begin
      stamp_now <= stamp_now + 8'h01;
    end
  end

  // Source search for learning; a hit only refreshes, a miss claims a slot
  always_comb begin
    learn_hit = '0;
    for (int i = 0; i < SFD_DYN_DEPTH; i++) begin
      learn_hit[i] = dyn_valid[i] && dyn_match(dyn_mem[i], lk.sa, lk.filter_id);
    end
  end

  // Slot bookkeeping; slots are reused round robin, not by age
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dyn_valid <= '0;
      next_free <= '0;
    end else if (learn_in && (learn_hit == '0)) begin
      dyn_valid[next_free] <= 1'b1;
      next_free            <= next_free + 4'h1;
    end
  end

  // Entry contents and stamps kept out of reset so they stay plain memory
  always_ff @(posedge clk_sys_in) begin
    if (learn_in) begin
      for (int i = 0; i < SFD_DYN_DEPTH; i++) begin
        if (learn_hit[i]) begin
          dyn_stamp[i] <= stamp_now;
        end
      end
      if (learn_hit == '0) begin
        dyn_mem[next_free]   <= {5'h00, learn_port_in, lk.filter_id, 1'b0, lk.sa};
        dyn_stamp[next_free] <= stamp_now;
      end
    end
  end
endmodule : sfd_mac_tables

// file: rtl/sfd_forward.sv
// Forwarding decision: MLD trapping, VLAN lookup, address resolution, mirroring
`timescale 1ns/1ps
// Behaviour
// - With MLD snooping on, multicast IPv6 with hop limit 1 goes only to processor
// - Next header 1 or 58, or hop-by-hop then 1 or 58, qualifies
// - Extended option also qualifies headers 43, 44, 50, 51, 60 likewise
// - Packets from receive-mirror ports also go to the mirror port
// - Optionally errored received packets still reach the mirror port
// - Packets toward transmit-mirror ports also go to the mirror port
// - Dual mode mirrors only receive-source to transmit-source traffic
// - Mirror sources and destination are free per-port settings
// - 128-entry VLAN table maps VIDs to 7-bit filter id
// - Untagged or null VID packets use the port default VID in 802.1Q mode
// - Invalid VID drops the packet and suppresses learning
// - No usable static and dynamic miss floods to VLAN members
// - No usable static but dynamic hit sends to dynamic entry port
// - Usable static entry sends to its port map
// - Learn source plus filter id if absent, else refresh its time stamp
// - Per-port ingress filtering and non-default-VID discard controls
// - Tail tag toward processor carries source port in bits 1:0
module sfd_forward
  import sfd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Global configuration
  input  wire logic        mld_snoop_en_in,
  input  wire logic        extended_header_trap_option_in,
  input  wire logic        vlan_mode_en_in,
  input  wire logic        mirror_dual_in,
  input  wire logic        mirror_bad_en_in,
  input  wire logic        tail_tag_en_in,
  // Per port configuration
  input  wire logic [4:0]  rx_mirror_src_in,
  input  wire logic [4:0]  tx_mirror_src_in,
  input  wire logic [4:0]  mirror_dest_in,
  input  wire logic [4:0]  ingress_filter_en_in,
  input  wire logic [4:0]  discard_non_default_in,
  input  wire logic [59:0] port_default_vlan_id_in,
  // VLAN table programming
  input  wire logic        vlan_we_in,
  input  wire logic [6:0]  vlan_idx_in,
  input  wire logic [12:0] vlan_entry_in,
  // Static table programming
  input  wire logic        sta_we_in,
  input  wire logic [2:0]  sta_idx_in,
  input  wire logic [63:0] sta_entry_in,
  // Packet descriptor
  input  wire logic        pkt_valid_in,
  input  wire logic [2:0]  pkt_src_port_in,
  input  wire logic [47:0] pkt_da_in,
  input  wire logic [47:0] pkt_sa_in,
  input  wire logic        pkt_tagged_in,
  input  wire logic [11:0] pkt_vid_in,
  input  wire logic        pkt_error_in,
  input  wire logic        pkt_ipv6_in,
  input  wire logic [7:0]  pkt_hop_limit_in,
  input  wire logic [7:0]  pkt_next_hdr_in,
  input  wire logic [7:0]  pkt_hbh_next_hdr_in,
  // Decision
  output logic             dec_valid_out,
  output logic [4:0]       dec_port_map_out,
  output logic             dec_drop_out,
  output logic             dec_trapped_out,
  output logic [7:0]       dec_tail_tag_out
);
  import sfd_pkg::*;

  sfd_lookup_if lk ();

  logic [12:0] vlan_mem [SFD_VLAN_DEPTH];
  logic [11:0] eff_vid;
  logic [12:0] vent;
  logic        vid_ok;
  logic        port_drop;
  logic        sta_usable;
  sfd_dest_t   dest_kind;
  logic [4:0]  lookup_map;
  logic [4:0]  src_bit;
  logic        mld_trap;
  logic        rx_mir;
  logic        tx_mir;
  logic        do_mirror;
  logic [4:0]  next_map;
  logic        next_drop;
  logic        learn;

  // Header code classes, used for both next header positions
  function automatic logic nh_basic(input logic [7:0] nh);
    nh_basic = (nh == SFD_NH_ICMP4) || (nh == SFD_NH_ICMP6);
  endfunction

  function automatic logic nh_ext(input logic [7:0] nh);
    nh_ext = (nh == SFD_NH_ROUTE) || (nh == SFD_NH_FRAG) || (nh == SFD_NH_ESP) ||
             (nh == SFD_NH_AUTH) || (nh == SFD_NH_DEST);
  endfunction

  function automatic logic nh_qual(input logic [7:0] nh, input logic ext);
    nh_qual = nh_basic(nh) || (ext && nh_ext(nh));
  endfunction

  function automatic logic [4:0] port_bit(input logic [2:0] p);
    port_bit = 5'h01 << p;
  endfunction

  // VLAN table writes; the table is only a 7-bit index of the VID space
  always_ff @(posedge clk_sys_in) begin
    if (vlan_we_in) begin
      vlan_mem[vlan_idx_in] <= vlan_entry_in;
    end
  end

  sfd_mac_tables u_tables (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .lk            (lk),
    .learn_in      (learn),
    .learn_port_in (pkt_src_port_in),
    .sta_we_in     (sta_we_in),
    .sta_idx_in    (sta_idx_in),
    .sta_entry_in  (sta_entry_in)
  );

  // VID selection and VLAN lookup
  always_comb begin
    src_bit = port_bit(pkt_src_port_in);
    eff_vid = pkt_vid_in;
    if (!pkt_tagged_in || (pkt_vid_in == SFD_NULL_VID)) begin
      eff_vid = port_default_vlan_id_in[pkt_src_port_in*12 +: 12];
    end
    vent   = vlan_mem[eff_vid[SFD_VIDX_W-1:0]];
    vid_ok = !vlan_mode_en_in || vent[SFD_VE_VALID];
    port_drop = 1'b0;
    if (vlan_mode_en_in && (discard_non_default_in & src_bit) != 5'h00 &&
        pkt_tagged_in && (pkt_vid_in != port_default_vlan_id_in[pkt_src_port_in*12 +: 12])) begin
      port_drop = 1'b1;
    end
    if (vlan_mode_en_in && (ingress_filter_en_in & src_bit) != 5'h00 &&
        (vent[SFD_VE_MEM_LSB +: 5] & src_bit) == 5'h00) begin
      port_drop = 1'b1;
    end
  end

  // Lookup channel drive
  assign lk.da  = pkt_da_in;
  assign lk.sa  = pkt_sa_in;
  assign lk.filter_id = vlan_mode_en_in ? vent[SFD_VE_FID_LSB +: 7] : 7'h00;

  // Address resolution
  always_comb begin
    sta_usable = lk.sta_hit && (!lk.sta_use_fid || (lk.sta_fid == lk.filter_id));
    if (sta_usable) begin
      dest_kind = SFD_DEST_STATIC;
    end else if (lk.dyn_da_hit) begin
      dest_kind = SFD_DEST_DYNAMIC;
    end else begin
      dest_kind = SFD_DEST_FLOOD;
    end
    case (dest_kind)
      SFD_DEST_STATIC:  lookup_map = lk.sta_map;
      SFD_DEST_DYNAMIC: lookup_map = port_bit(lk.dyn_da_port);
      default: begin
        // Without VLAN mode flooding reaches every port except the source port
        lookup_map = vlan_mode_en_in ? vent[SFD_VE_MEM_LSB +: 5] : 5'h1F;
      end
    endcase
    lookup_map = lookup_map & ~src_bit;
  end

  // MLD trap and mirror combination
  always_comb begin
    mld_trap = mld_snoop_en_in && pkt_ipv6_in && pkt_da_in[40] &&
               (pkt_hop_limit_in == SFD_HOP_ONE) &&
               (nh_qual(pkt_next_hdr_in, extended_header_trap_option_in) ||
                ((pkt_next_hdr_in == SFD_NH_HOPBYHOP) &&
                 nh_qual(pkt_hbh_next_hdr_in, extended_header_trap_option_in)));
    rx_mir = (rx_mirror_src_in & src_bit) != 5'h00;
    tx_mir = (tx_mirror_src_in & lookup_map) != 5'h00;
    if (mirror_dual_in) begin
      do_mirror = rx_mir && tx_mir;
    end else begin
      do_mirror = rx_mir || tx_mir;
    end
    next_drop = !vid_ok || port_drop || (pkt_error_in && !(do_mirror && mirror_bad_en_in));
    if (mld_trap) begin
      next_map = port_bit(3'(SFD_CPU_PORT));
    end else if (pkt_error_in) begin
      next_map = (do_mirror && mirror_bad_en_in) ? mirror_dest_in : 5'h00;
    end else begin
      // OR merge means overlap with a lookup port yields one copy only
      next_map = lookup_map | (do_mirror ? mirror_dest_in : 5'h00);
    end
    if (!vid_ok || port_drop) begin
      next_map = 5'h00;
    end
    learn = pkt_valid_in && vid_ok && !port_drop && !pkt_error_in;
  end

  // Registered decision outputs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dec_valid_out    <= 1'b0;
      dec_port_map_out <= SFD_MAP_RST;
      dec_drop_out     <= 1'b0;
      dec_trapped_out  <= 1'b0;
    end else begin
      dec_valid_out    <= pkt_valid_in;
      dec_port_map_out <= pkt_valid_in ? next_map : SFD_MAP_RST;
      dec_drop_out     <= pkt_valid_in && (next_drop || next_map == 5'h00);
      dec_trapped_out  <= pkt_valid_in && mld_trap && vid_ok && !port_drop;
    end
  end

  // Tail tag byte for frames toward the processor
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dec_tail_tag_out <= SFD_TAG_RST;
    end else if (pkt_valid_in && tail_tag_en_in) begin
      dec_tail_tag_out <= {6'h00, pkt_src_port_in[1:0]};
    end else begin
      dec_tail_tag_out <= SFD_TAG_RST;
    end
  end
endmodule : sfd_forward

// file: tb/sfd_host_model.sv
// Host processor side model: setting handed to the switch by the configuring host
`timescale 1ns/1ps
module sfd_host_model (
  // Host intent
  input  wire logic mld_use_in,
  input  wire logic tag_req_in,
  // Setting handed to the switch
  output logic      tail_tag_en_out
);
  // Tagging held on while trapping runs, else trapped frames lose their port
  assign tail_tag_en_out = tag_req_in | mld_use_in;
endmodule : sfd_host_model

// file: tb/sfd_forward_asserts.sv
// Checker for decision timing, trapping, tail tag and mirroring of the forwarding block
`timescale 1ns/1ps
module sfd_forward_asserts (
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  // Watched inputs
  input wire logic        mld_snoop_en_in,
  input wire logic        vlan_mode_en_in,
  input wire logic        mirror_dual_in,
  input wire logic        tail_tag_en_in,
  input wire logic [4:0]  rx_mirror_src_in,
  input wire logic [4:0]  mirror_dest_in,
  input wire logic        pkt_valid_in,
  input wire logic [2:0]  pkt_src_port_in,
  input wire logic [47:0] pkt_da_in,
  input wire logic        pkt_error_in,
  input wire logic        pkt_ipv6_in,
  input wire logic [7:0]  pkt_hop_limit_in,
  input wire logic [7:0]  pkt_next_hdr_in,
  // Watched outputs
  input wire logic        dec_valid_out,
  input wire logic [4:0]  dec_port_map_out,
  input wire logic        dec_drop_out,
  input wire logic        dec_trapped_out,
  input wire logic [7:0]  dec_tail_tag_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  chk_answer_one_cycle: assert property (pkt_valid_in |=> dec_valid_out)
    else $error("decision not one cycle after descriptor");
  chk_idle_quiet: assert property (!pkt_valid_in |=> !dec_valid_out && !dec_trapped_out
    && dec_port_map_out == 5'h00) else $error("decision without descriptor");
  chk_trap_cpu_only: assert property (dec_trapped_out |-> dec_valid_out && !dec_drop_out
    && dec_port_map_out == 5'h10) else $error("trapped packet not only to processor");
  chk_trap_listener: assert property (pkt_valid_in && mld_snoop_en_in && pkt_ipv6_in
    && pkt_da_in[40] && pkt_hop_limit_in == 8'h01 && pkt_next_hdr_in == 8'h3A && !pkt_error_in
    && !vlan_mode_en_in && pkt_src_port_in != 3'h4 |=> dec_trapped_out)
    else $error("listener packet not trapped");
  chk_trap_off: assert property (pkt_valid_in && !mld_snoop_en_in |=> !dec_trapped_out)
    else $error("trap while snooping off");
  chk_tag_source: assert property (pkt_valid_in && tail_tag_en_in
    |=> dec_tail_tag_out == {6'h00, $past(pkt_src_port_in[1:0])})
    else $error("tail tag source port wrong");
  chk_tag_off: assert property (!tail_tag_en_in |=> dec_tail_tag_out == 8'h00)
    else $error("tail tag while tagging off");
  chk_rx_mirror: assert property (dec_valid_out && !dec_drop_out && !dec_trapped_out
    && $past(rx_mirror_src_in[pkt_src_port_in] && !mirror_dual_in)
    |-> (dec_port_map_out & $past(mirror_dest_in)) != 5'h00)
    else $error("receive mirror copy missing");
endmodule : sfd_forward_asserts
bind sfd_forward sfd_forward_asserts i_sfd_forward_asserts (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .mld_snoop_en_in(mld_snoop_en_in),
  .vlan_mode_en_in(vlan_mode_en_in), .mirror_dual_in(mirror_dual_in),
  .tail_tag_en_in(tail_tag_en_in), .rx_mirror_src_in(rx_mirror_src_in),
  .mirror_dest_in(mirror_dest_in), .pkt_valid_in(pkt_valid_in),
  .pkt_src_port_in(pkt_src_port_in), .pkt_da_in(pkt_da_in), .pkt_error_in(pkt_error_in),
  .pkt_ipv6_in(pkt_ipv6_in), .pkt_hop_limit_in(pkt_hop_limit_in),
  .pkt_next_hdr_in(pkt_next_hdr_in), .dec_valid_out(dec_valid_out),
  .dec_port_map_out(dec_port_map_out), .dec_drop_out(dec_drop_out),
  .dec_trapped_out(dec_trapped_out), .dec_tail_tag_out(dec_tail_tag_out)
);

// file: tb/sfd_forward_tb.sv
// Self-checking bench for the forwarding decision block
`timescale 1ns/1ps
module sfd_forward_tb;
  import sfd_pkg::*;
  logic        clk_sys_in = 0, rst_in = 1, tag_req = 1, tail_tag_en_in;
  logic        mld_snoop_en_in = 0, extended_header_trap_option_in = 0, vlan_mode_en_in = 0;
  logic        mirror_dual_in = 0, mirror_bad_en_in = 0, vlan_we_in = 0, sta_we_in = 0;
  logic        pkt_valid_in = 0, pkt_tagged_in = 0, pkt_error_in = 0, pkt_ipv6_in = 0;
  logic [4:0]  rx_mirror_src_in = 0, tx_mirror_src_in = 0, mirror_dest_in = 0;
  logic [4:0]  ingress_filter_en_in = 0, discard_non_default_in = 0, dec_port_map_out;
  logic [59:0] port_default_vlan_id_in = {12'h002, 12'h003, 12'h002, 12'h002, 12'h002};
  logic [6:0]  vlan_idx_in = 0;
  logic [12:0] vlan_entry_in = 0;
  logic [2:0]  sta_idx_in = 0, pkt_src_port_in = 0;
  logic [63:0] sta_entry_in = 0, st0 = 0;
  logic [47:0] pkt_da_in = 0, pkt_sa_in = 0;
  logic [11:0] pkt_vid_in = 0;
  logic [7:0]  pkt_hop_limit_in = 0, pkt_next_hdr_in = 0, pkt_hbh_next_hdr_in = 0;
  logic [7:0]  dec_tail_tag_out;
  logic        dec_valid_out, dec_drop_out, dec_trapped_out;
  logic [47:0] da_unk = 48'h0200000000A1, da_sta = 48'h020000000055, da_mc = 48'h333300000001;
  logic [47:0] sa_b = 48'h0400000000B0, sa_c = 48'h0400000000C0, sa_d = 48'h0400000000D0;
  logic [47:0] sa_e = 48'h0400000000E0;
  int          miscompares = 0, comparisons = 0, seed = 32'h09A8;
  int          vf[128], vm[128], vv[128], pv[5] = '{2, 2, 2, 3, 2};
  int          codes[8] = '{1, 58, 43, 44, 50, 51, 60, 17};
  int          dyn[logic [54:0]];
  // Free running system clock
  always #25 clk_sys_in = ~clk_sys_in;
  sfd_host_model i_sfd_host_model (.mld_use_in(mld_snoop_en_in), .tag_req_in(tag_req),
                                   .tail_tag_en_out(tail_tag_en_in));
  sfd_forward i_sfd_forward (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .mld_snoop_en_in(mld_snoop_en_in),
    .extended_header_trap_option_in(extended_header_trap_option_in),
    .vlan_mode_en_in(vlan_mode_en_in), .mirror_dual_in(mirror_dual_in),
    .mirror_bad_en_in(mirror_bad_en_in), .tail_tag_en_in(tail_tag_en_in),
    .rx_mirror_src_in(rx_mirror_src_in), .tx_mirror_src_in(tx_mirror_src_in),
    .mirror_dest_in(mirror_dest_in), .ingress_filter_en_in(ingress_filter_en_in),
    .discard_non_default_in(discard_non_default_in),
    .port_default_vlan_id_in(port_default_vlan_id_in),
    .vlan_we_in(vlan_we_in), .vlan_idx_in(vlan_idx_in), .vlan_entry_in(vlan_entry_in),
    .sta_we_in(sta_we_in), .sta_idx_in(sta_idx_in), .sta_entry_in(sta_entry_in),
    .pkt_valid_in(pkt_valid_in), .pkt_src_port_in(pkt_src_port_in), .pkt_da_in(pkt_da_in),
    .pkt_sa_in(pkt_sa_in), .pkt_tagged_in(pkt_tagged_in), .pkt_vid_in(pkt_vid_in),
    .pkt_error_in(pkt_error_in), .pkt_ipv6_in(pkt_ipv6_in),
    .pkt_hop_limit_in(pkt_hop_limit_in), .pkt_next_hdr_in(pkt_next_hdr_in),
    .pkt_hbh_next_hdr_in(pkt_hbh_next_hdr_in), .dec_valid_out(dec_valid_out),
    .dec_port_map_out(dec_port_map_out), .dec_drop_out(dec_drop_out),
    .dec_trapped_out(dec_trapped_out), .dec_tail_tag_out(dec_tail_tag_out)
  );
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic bit qual(input logic [7:0] c);
    return c == 1 || c == 58 || (extended_header_trap_option_in && c inside {43, 44, 50, 51, 60});
  endfunction
  // Reference decision, then drive one descriptor and compare the answer
  task automatic send(input int src, tg, vid, err, input logic [47:0] da, sa);
    int v, ok, filter_id, m, mir, trap, pass;
    v = (tg && vid != 0) ? vid : pv[src];
    ok = vlan_mode_en_in ? vv[v % 128] : 1;
    filter_id = vlan_mode_en_in ? vf[v % 128] : 0;
    m = vlan_mode_en_in ? vm[v % 128] : 31;
    pass = ok && !(vlan_mode_en_in && ((ingress_filter_en_in[src] && !vm[v % 128][src])
           || (discard_non_default_in[src] && tg && vid != pv[src])));
    if (st0[53] && st0[47:0] == da && (!st0[54] || st0[61:55] == filter_id[6:0])) m = st0[52:48];
    else if (dyn.exists({filter_id[6:0], da})) m = 1 << dyn[{filter_id[6:0], da}];
    m &= ~(1 << src);
    if (pass && !err && !dyn.exists({filter_id[6:0], sa})) dyn[{filter_id[6:0], sa}] = src;
    mir = mirror_dual_in ? rx_mirror_src_in[src] && (m & tx_mirror_src_in) != 0
                         : rx_mirror_src_in[src] || (m & tx_mirror_src_in) != 0;
    if (mir) m |= mirror_dest_in;
    if (err) m = (mir && mirror_bad_en_in) ? mirror_dest_in : 0;
    trap = pass && mld_snoop_en_in && pkt_ipv6_in && da[40] && pkt_hop_limit_in == 1
           && (qual(pkt_next_hdr_in) || (pkt_next_hdr_in == 0 && qual(pkt_hbh_next_hdr_in)));
    if (trap) m = 16;
    if (!pass) m = 0;
    @(negedge clk_sys_in);
    pkt_src_port_in = src[2:0];
    pkt_tagged_in = tg[0];
    pkt_vid_in = vid[11:0];
    pkt_error_in = err[0];
    pkt_da_in = da;
    pkt_sa_in = sa;
    pkt_valid_in = 1;
    @(negedge clk_sys_in);
    pkt_valid_in = 0;
    chk("valid", dec_valid_out, 1);
    chk("map", dec_port_map_out, m[4:0]);
    chk("drop", dec_drop_out, m == 0);
    chk("trap", dec_trapped_out, trap[0]);
    chk("tag", dec_tail_tag_out, (tag_req | mld_snoop_en_in) ? {6'h00, src[1:0]} : 8'h00);
  endtask
  task automatic vset(input int ix, filter_id, mem, val);
    @(negedge clk_sys_in);
    vlan_we_in = 1;
    vlan_idx_in = ix[6:0];
    vlan_entry_in = {val[0], mem[4:0], filter_id[6:0]};
    {vf[ix], vm[ix], vv[ix]} = {filter_id, mem, val};
    @(negedge clk_sys_in);
    vlan_we_in = 0;
  endtask
  task automatic sset(input int ix, input logic [63:0] e);
    @(negedge clk_sys_in);
    sta_we_in = 1;
    sta_idx_in = ix[2:0];
    sta_entry_in = e;
    st0 = (ix == 0) ? e : st0;
    @(negedge clk_sys_in);
    sta_we_in = 0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog sized well above the expected run
  initial begin
    #(50 * 4000);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (16) @(negedge clk_sys_in);
    rst_in = 0;
    for (int i = 0; i < 8; i++) begin
      sset(i, 64'h0);
    end
    sset(0, {2'h0, 7'h09, 2'h3, 5'h18, da_sta});
    vset(2, 9, 15, 1);
    vset(3, 9, 19, 1);
    vset(4, 6, 31, 1);
    vset(5, 0, 0, 0);
    vlan_mode_en_in = 1;
    send(0, 0, 0, 0, da_unk, sa_b);
    send(1, 1, 2, 0, sa_b, sa_c);
    send(2, 1, 2, 0, da_sta, sa_d);
    send(1, 1, 4, 0, da_sta, sa_d);
    send(3, 1, 4, 0, da_unk, da_sta);
    send(1, 1, 4, 0, da_sta, sa_d);
    send(2, 1, 5, 0, da_unk, sa_e);
    send(0, 1, 2, 0, sa_e, sa_d);
    send(1, 1, 0, 0, da_unk, sa_d);
    {ingress_filter_en_in, discard_non_default_in} = {5'h10, 5'h08};
    send(4, 1, 2, 0, da_unk, sa_c);
    send(3, 1, 2, 0, da_unk, sa_c);
    send(3, 1, 3, 0, da_unk, sa_c);
    {ingress_filter_en_in, discard_non_default_in} = 10'h000;
    repeat (6) send($unsigned($random(seed)) % 4, 1, 2 + $unsigned($random(seed)) % 2, 0,
                    {16'h0200, 32'($random(seed))}, sa_b);
    $display("test vlan lookup done");
    {mirror_dest_in, rx_mirror_src_in} = {5'h10, 5'h02};
    send(1, 1, 2, 0, da_unk, sa_d);
    send(1, 1, 2, 1, da_unk, sa_d);
    mirror_bad_en_in = 1;
    send(1, 1, 2, 1, da_unk, sa_d);
    {mirror_dest_in, rx_mirror_src_in, tx_mirror_src_in} = {5'h04, 5'h00, 5'h01};
    send(2, 1, 2, 0, sa_b, sa_d);
    {rx_mirror_src_in, mirror_dual_in} = {5'h02, 1'b1};
    send(1, 1, 2, 0, sa_b, sa_d);
    send(2, 1, 2, 0, sa_b, sa_d);
    {tx_mirror_src_in, mirror_dual_in} = {5'h00, 1'b0};
    send(1, 1, 2, 0, da_unk, sa_d);
    {rx_mirror_src_in, mirror_dest_in, vlan_mode_en_in} = 11'h000;
    $display("test mirror done");
    {mld_snoop_en_in, pkt_ipv6_in, pkt_hop_limit_in} = {2'h3, 8'h01};
    for (int o = 0; o < 2; o++) begin
      for (int h = 0; h < 2; h++) begin
        foreach (codes[i]) begin
          extended_header_trap_option_in = o[0];
          pkt_next_hdr_in = h ? 8'h00 : codes[i][7:0];
          pkt_hbh_next_hdr_in = codes[i][7:0];
          send(2, 0, 0, 0, da_mc, sa_e);
        end
      end
    end
    pkt_next_hdr_in = 8'h3A;
    send(2, 0, 0, 0, da_unk, sa_e);
    pkt_ipv6_in = 0;
    send(2, 0, 0, 0, da_mc, sa_e);
    {pkt_ipv6_in, pkt_hop_limit_in} = {1'b1, 8'h02};
    send(2, 0, 0, 0, da_mc, sa_e);
    {mld_snoop_en_in, pkt_hop_limit_in, tag_req} = {1'b0, 8'h01, 1'b0};
    send(1, 0, 0, 0, da_mc, sa_e);
    $display("test trapping done");
    finish_test();
  end
endmodule : sfd_forward_tb
